// ### rtl/acg_pkg.sv
// package of register map, field layout and reset values for the
// record-path channel gain and phase configuration bank.
// assumes a 32-bit AXI4-Lite register bus; one register to a word.
package acg_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CH2_VOLUME      = 8'h57;
    localparam logic [7:0] IDX_CH2_GAIN_TRIM   = 8'h58;
    localparam logic [7:0] IDX_CH2_PHASE_DELAY = 8'h59;
    localparam logic [7:0] IDX_CH3_INPUT_COPY  = 8'h5a;
    localparam logic [7:0] IDX_CH3_VOLUME      = 8'h5b;
    localparam logic [7:0] IDX_CH3_GAIN_TRIM   = 8'h5c;
    localparam logic [7:0] IDX_STATUS          = 8'h7f;

    // reset values
    localparam logic [7:0] RST_VOLUME      = 8'ha1;
    localparam logic [7:0] RST_GAIN_TRIM   = 8'h80;
    localparam logic [7:0] RST_PHASE_DELAY = 8'h00;
    localparam logic [7:0] RST_INPUT_COPY  = 8'h00;

    // writable bits of each register; the rest read as zero
    localparam logic [7:0] MASK_VOLUME      = 8'hff;
    localparam logic [7:0] MASK_GAIN_TRIM   = 8'hf0;
    localparam logic [7:0] MASK_PHASE_DELAY = 8'hfc;
    localparam logic [7:0] MASK_INPUT_COPY  = 8'h80;

    // field positions
    localparam int TRIM_LSB  = 4;
    localparam int PHASE_LSB = 2;
    localparam int COPY_BIT  = 7;

    // status bits
    localparam int ST_FULL   = 0;
    localparam int ST_VALID  = 1;
    localparam int ST_MUTE2  = 2;
    localparam int ST_MUTE3  = 3;

    // gain coding
    localparam logic [7:0] VOL_MUTE   = 8'h00;
    localparam logic [9:0] VOL_UNITY  = 10'h0a1;
    localparam logic [9:0] HALF_BIAS  = 10'h0a8;
    localparam logic [8:0] HALF_OCT   = 9'h00c;
    localparam int         OCT_BIAS   = 14;
    localparam int         GAIN_FRAC  = 15;
    // q15 trim per octave away from unity, as 6 dB is just under x2
    localparam int         OCT_TRIM   = 78;
    localparam int         PHASE_TAPS = 63;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### rtl/acg_top.sv
// channel 2 and channel 3 record-path gain and mute, channel 2 phase delay and
// channel 3 input copy, with an AXI4-Lite register bank.
// assumes mod_tick marks modulator clock cycles on sys_clk and that
// decimated sample pairs arrive on sys_clk with valid/ready.
//
// How it works
// - a volume code of zero forces that channel's samples to zero.
// - volume code one is -80 dB and each code step adds 0.5 dB.
// - code 161 is unity, 162 is +0.5 dB, and 255 gives +47 dB.
// - each volume register is eight bits wide and resets to 161.
// - the trim nibble in bits 7..4 steps 0.1 dB with code 8 at 0 dB.
// - the trim register resets to 0x80 with its low nibble clear.
// - the phase code in bits 7..2 delays channel 2 by that many ticks.
// - with the copy bit set, channel 3's filter input is channel 1's.
`timescale 1ns/100ps

module acg_top #(
    parameter int ADDR_W    = 12,
    parameter int SW        = 24,
    parameter int MOD_W     = 4,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              mod_tick,
    input  wire logic [MOD_W-1:0]  ch1_mod,
    input  wire logic [MOD_W-1:0]  ch2_mod,
    input  wire logic [MOD_W-1:0]  ch3_mod,
    output logic [MOD_W-1:0]       ch2_filt_in,
    output logic [MOD_W-1:0]       ch3_filt_in,
    input  wire logic              smp_valid,
    output logic                   smp_ready,
    input  wire logic [SW-1:0]     smp_ch2,
    input  wire logic [SW-1:0]     smp_ch3,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [SW-1:0]          out_ch2,
    output logic [SW-1:0]          out_ch3
);
    import acg_pkg::*;

    // ----------------------------------------------------------------
    // structure
    // ----------------------------------------------------------------
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam int PW    = SW + 34;
    localparam int EW    = PW + 2 * OCT_BIAS;
    localparam int SHIFT = 2 * GAIN_FRAC + OCT_BIAS;

    generate
        if (ADDR_W < 9 || ADDR_W > 32)
            $error("ADDR_W must lie between 9 and 32");
        if (SW < 2 || MOD_W < 1)
            $error("SW and MOD_W too small");
        if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
            $error("BUF_DEPTH must be a power of two, two or more");
    endgenerate

    typedef struct packed {
        logic                                aw_held;
        logic [ADDR_W-1:0]                   aw_addr;
        logic                                w_held;
        logic [7:0]                          w_byte;
        logic                                w_lane;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [1:0]                          rresp;
        logic [31:0]                         rdata;
        logic [7:0]                          ch2_volume;
        logic [7:0]                          ch2_gain_trim;
        logic [7:0]                          ch2_phase_delay;
        logic [7:0]                          ch3_input_copy;
        logic [7:0]                          ch3_volume;
        logic [7:0]                          ch3_gain_trim;
        logic [PHASE_TAPS-1:0][MOD_W-1:0]    dline;
        logic [MOD_W-1:0]                    f2;
        logic [MOD_W-1:0]                    f3;
        logic [BUF_DEPTH-1:0][2*SW-1:0]      fifo;
        logic [PTR_W-1:0]                    wp;
        logic [PTR_W-1:0]                    rp;
        logic [CNT_W-1:0]                    cnt;
    } acg_state_t;

    acg_state_t s;
    acg_state_t next_s;

    // ----------------------------------------------------------------
    // gain tables, q15
    // ----------------------------------------------------------------
    function automatic logic [15:0] half_db(input logic [3:0] r);
        case (r)
            4'h0:    half_db = 16'h8000;
            4'h1:    half_db = 16'h8796;
            4'h2:    half_db = 16'h8f9e;
            4'h3:    half_db = 16'h9821;
            4'h4:    half_db = 16'ha125;
            4'h5:    half_db = 16'haab2;
            4'h6:    half_db = 16'hb4ce;
            4'h7:    half_db = 16'hbf86;
            4'h8:    half_db = 16'hcadf;
            4'h9:    half_db = 16'hd6e3;
            4'ha:    half_db = 16'he3a0;
            default: half_db = 16'hf11c;
        endcase
    endfunction

    function automatic logic [15:0] trim_db(input logic [3:0] c);
        case (c)
            4'h0: trim_db = 16'h74bd;
            4'h1: trim_db = 16'h7617;
            4'h2: trim_db = 16'h7776;
            4'h3: trim_db = 16'h78d7;
            4'h4: trim_db = 16'h7a3d;
            4'h5: trim_db = 16'h7ba8;
            4'h6: trim_db = 16'h7d16;
            4'h7: trim_db = 16'h7e89;
            4'h8: trim_db = 16'h8000;
            4'h9: trim_db = 16'h817c;
            4'ha: trim_db = 16'h82fb;
            4'hb: trim_db = 16'h8480;
            4'hc: trim_db = 16'h8608;
            4'hd: trim_db = 16'h8796;
            4'he: trim_db = 16'h8928;
            4'hf: trim_db = 16'h8abe;
        endcase
    endfunction

    // volume in half-dB steps split into 6 dB octaves and a remainder
    function automatic logic [SW-1:0] apply_gain(
        input logic [SW-1:0] smp,
        input logic [7:0]    vol,
        input logic [3:0]    trim
    );
        logic [8:0]           hp;
        logic [4:0]           oct;
        logic [3:0]           rem;
        logic [16:0]          corr;
        logic [15:0]          tc;
        logic signed [PW-1:0] prod;
        logic signed [EW-1:0] wide;
        hp   = 9'(10'({2'h0, vol}) - VOL_UNITY + HALF_BIAS);
        oct  = 5'(hp / HALF_OCT);
        rem  = 4'(hp % HALF_OCT);
        corr = 17'(18'h08000 - 18'(OCT_TRIM) * (18'(oct) - 18'(OCT_BIAS)));
        tc   = 16'((33'(trim_db(trim)) * 33'(corr)) >> GAIN_FRAC);
        prod = PW'($signed(smp) * $signed({1'b0, half_db(rem)})
               * $signed({1'b0, tc}));
        wide = (EW'(prod) <<< oct) >>> SHIFT;
        if (vol == VOL_MUTE)
            apply_gain = '0;
        else if (wide[EW-1:SW-1] == '0 || wide[EW-1:SW-1] == '1)
            apply_gain = wide[SW-1:0];
        else
            apply_gain = {wide[EW-1], {(SW-1){~wide[EW-1]}}};
    endfunction

    // ----------------------------------------------------------------
    // register read decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    logic [31:0] rd_word;
    logic        rd_err;
    logic [7:0]  status;

    always_comb begin
        status           = '0;
        status[ST_FULL]  = (s.cnt == CNT_W'(BUF_DEPTH));
        status[ST_VALID] = (s.cnt != '0);
        status[ST_MUTE2] = (s.ch2_volume == VOL_MUTE);
        status[ST_MUTE3] = (s.ch3_volume == VOL_MUTE);
        rd_err  = 1'b0;
        rd_word = '0;
        if (hit(s_axi_araddr, IDX_CH2_VOLUME))
            rd_word[7:0] = s.ch2_volume;
        else if (hit(s_axi_araddr, IDX_CH2_GAIN_TRIM))
            rd_word[7:0] = s.ch2_gain_trim;
        else if (hit(s_axi_araddr, IDX_CH2_PHASE_DELAY))
            rd_word[7:0] = s.ch2_phase_delay;
        else if (hit(s_axi_araddr, IDX_CH3_INPUT_COPY))
            rd_word[7:0] = s.ch3_input_copy;
        else if (hit(s_axi_araddr, IDX_CH3_VOLUME))
            rd_word[7:0] = s.ch3_volume;
        else if (hit(s_axi_araddr, IDX_CH3_GAIN_TRIM))
            rd_word[7:0] = s.ch3_gain_trim;
        else if (hit(s_axi_araddr, IDX_STATUS))
            rd_word[7:0] = status;
        else
            rd_err = 1'b1;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic                  push;
    logic                  pop;
    logic [SW-1:0]         g2;
    logic [SW-1:0]         g3;
    logic [5:0]            pcode;

    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready  = !s.w_held && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign smp_ready     = (s.cnt != CNT_W'(BUF_DEPTH));
    assign out_valid     = (s.cnt != '0);
    assign push          = smp_valid && smp_ready;
    assign pop           = out_valid && out_ready;
    assign pcode         = s.ch2_phase_delay[PHASE_LSB +: 6];

    always_comb begin
        next_s = s;
        g2 = apply_gain(smp_ch2, s.ch2_volume,
                        s.ch2_gain_trim[TRIM_LSB +: 4]);
        g3 = apply_gain(smp_ch3, s.ch3_volume,
                        s.ch3_gain_trim[TRIM_LSB +: 4]);
        // write channels
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_held = 1'b1;
            next_s.w_byte = s_axi_wdata[7:0];
            next_s.w_lane = s_axi_wstrb[0];
        end
        if (s.aw_held && s.w_held) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            if (hit(s.aw_addr, IDX_CH2_VOLUME) && s.w_lane)
                next_s.ch2_volume = s.w_byte & MASK_VOLUME;
            else if (hit(s.aw_addr, IDX_CH2_GAIN_TRIM) && s.w_lane)
                next_s.ch2_gain_trim = s.w_byte & MASK_GAIN_TRIM;
            else if (hit(s.aw_addr, IDX_CH2_PHASE_DELAY) && s.w_lane)
                next_s.ch2_phase_delay = s.w_byte & MASK_PHASE_DELAY;
            else if (hit(s.aw_addr, IDX_CH3_INPUT_COPY) && s.w_lane)
                next_s.ch3_input_copy = s.w_byte & MASK_INPUT_COPY;
            else if (hit(s.aw_addr, IDX_CH3_VOLUME) && s.w_lane)
                next_s.ch3_volume = s.w_byte & MASK_VOLUME;
            else if (hit(s.aw_addr, IDX_CH3_GAIN_TRIM) && s.w_lane)
                next_s.ch3_gain_trim = s.w_byte & MASK_GAIN_TRIM;
            else if (!hit(s.aw_addr, IDX_STATUS)
                && (s.aw_addr[ADDR_W-1:2] < (ADDR_W-2)'(IDX_CH2_VOLUME)
                || s.aw_addr[ADDR_W-1:2] > (ADDR_W-2)'(IDX_CH3_GAIN_TRIM)))
                next_s.bresp = RESP_SLVERR;
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_word;
            next_s.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        // modulator-rate path
        if (mod_tick) begin
            next_s.dline = {s.dline[PHASE_TAPS-2:0], ch2_mod};
            if (pcode == '0)
                next_s.f2 = ch2_mod;
            else
                next_s.f2 = s.dline[pcode - 6'h01];
            if (s.ch3_input_copy[COPY_BIT])
                next_s.f3 = ch1_mod;
            else
                next_s.f3 = ch3_mod;
        end
        // decimated sample buffer
        if (push) begin
            next_s.fifo[s.wp] = {g2, g3};
            next_s.wp = s.wp + PTR_W'(1);
        end
        if (pop)
            next_s.rp = s.rp + PTR_W'(1);
        if (push && !pop)
            next_s.cnt = s.cnt + CNT_W'(1);
        else if (pop && !push)
            next_s.cnt = s.cnt - CNT_W'(1);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s                 <= '0;
            s.ch2_volume      <= RST_VOLUME;
            s.ch3_volume      <= RST_VOLUME;
            s.ch2_gain_trim   <= RST_GAIN_TRIM;
            s.ch3_gain_trim   <= RST_GAIN_TRIM;
            s.ch2_phase_delay <= RST_PHASE_DELAY;
            s.ch3_input_copy  <= RST_INPUT_COPY;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp  = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp  = s.rresp;
    assign s_axi_rdata  = s.rdata;
    assign ch2_filt_in  = s.f2;
    assign ch3_filt_in  = s.f3;
    assign out_ch2      = s.fifo[s.rp][2*SW-1:SW];
    assign out_ch3      = s.fifo[s.rp][SW-1:0];

endmodule

// ### verif/acg_assertions.sv
// checker for the channel gain and phase bank, port level only.
// assumes it is bound onto acg_top; one clock domain.
`timescale 1ns/100ps
module acg_assertions #(
    parameter int SW    = 24,
    parameter int MOD_W = 4
) (
    input wire logic             sys_clk,
    input wire logic             nrst,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic             mod_tick,
    input wire logic [MOD_W-1:0] ch2_filt_in,
    input wire logic [MOD_W-1:0] ch3_filt_in,
    input wire logic             smp_ready,
    input wire logic             out_valid,
    input wire logic             out_ready,
    input wire logic [SW-1:0]    out_ch2
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid after handshake");
    chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("rvalid after handshake");
    chk_ar_latency: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read answer");
    chk_aw_block: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    chk_rdata_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_filt_stable: assert property (
        !mod_tick |=> $stable(ch2_filt_in) && $stable(ch3_filt_in))
        else $error("filter input moved without tick");
    chk_smp_room: assert property (!out_valid |-> smp_ready)
        else $error("empty buffer refuses");
    chk_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_ch2))
        else $error("stalled sample lost");
endmodule

bind acg_top acg_assertions #(.SW(SW), .MOD_W(MOD_W)) chk_u (
    .sys_clk, .nrst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .mod_tick, .ch2_filt_in, .ch3_filt_in,
    .smp_ready, .out_valid, .out_ready, .out_ch2
);

// ### verif/acg_top_tb_top.sv
// self-checking bench for acg_top.
// assumes acg_pkg and the bound checker; 40 MHz clock.
`timescale 1ns/100ps
module acg_top_tb_top;
    import acg_pkg::*;
    // --------
    // signals
    // --------
    logic        sys_clk = 0, nrst = 0, mod_tick = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 0, ch1_mod = 0, ch2_mod = 0, ch3_mod = 0;
    logic [3:0]  ch2_filt_in, ch3_filt_in;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, smp_ready, out_valid;
    logic        smp_valid = 0, out_ready = 0;
    logic [23:0] smp_ch2 = 0, smp_ch3 = 0, out_ch2, out_ch3;
    int          n_errors = 0, cmp_count = 0;
    logic [7:0]  ia[6] = '{IDX_CH2_VOLUME, IDX_CH2_GAIN_TRIM,
        IDX_CH2_PHASE_DELAY, IDX_CH3_INPUT_COPY, IDX_CH3_VOLUME,
        IDX_CH3_GAIN_TRIM};
    logic [7:0]  ra[6] = '{RST_VOLUME, RST_GAIN_TRIM, RST_PHASE_DELAY,
        RST_INPUT_COPY, RST_VOLUME, RST_GAIN_TRIM};
    logic [7:0]  ma[6] = '{MASK_VOLUME, MASK_GAIN_TRIM, MASK_PHASE_DELAY,
        MASK_INPUT_COPY, MASK_VOLUME, MASK_GAIN_TRIM};

    acg_top dut_u (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mod_tick, .ch1_mod, .ch2_mod, .ch3_mod,
        .ch2_filt_in, .ch3_filt_in, .smp_valid, .smp_ready, .smp_ch2,
        .smp_ch3, .out_valid, .out_ready, .out_ch2, .out_ch3);

    always #12.5 sys_clk = ~sys_clk;
    // --------
    // tasks
    // --------
    task automatic chk(input logic [47:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic near(input logic [23:0] g, input int x,
                        input logic [7:0] v, input logic [3:0] t);
        real e, d, k;
        e = x * 10.0 ** (((v - 161.0) * 0.5 + (t - 8.0) * 0.1) / 20.0);
        d = $signed(g) - e;
        k = (v < 20) ? 0.04 : 0.005;
        cmp_count++;
        if ((^g) === 1'bx || d * d > e * e * k * k + 4.0) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g,
                     24'($rtoi(e)));
        end
    endtask

    task automatic wr(input logic [7:0] x, d, output logic [1:0] r);
        logic a, w, b;
        b = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= {2'h0, x, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!b) begin
            @(negedge sys_clk);
            a = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (a) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            if (b) s_axi_bready <= 0;
        end
        @(negedge sys_clk);
        chk(s_axi_bvalid, 0);
    endtask

    task automatic rd(input logic [7:0] x, output logic [31:0] d,
                      output logic [1:0] r);
        logic a, v;
        v = 0;
        @(posedge sys_clk);
        s_axi_araddr <= {2'h0, x, 2'h0};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!v) begin
            @(negedge sys_clk);
            a = s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (a) s_axi_arvalid <= 0;
            if (v) s_axi_rready <= 0;
        end
        @(negedge sys_clk);
        chk(s_axi_rvalid, 0);
    endtask

    task automatic push(input int a, b);
        logic k;
        k = 0;
        @(posedge sys_clk);
        smp_valid <= 1;
        smp_ch2 <= a[23:0];
        smp_ch3 <= b[23:0];
        while (!k) begin
            @(negedge sys_clk);
            k = smp_ready;
            @(posedge sys_clk);
            if (k) smp_valid <= 0;
        end
        @(negedge sys_clk);
        chk(out_valid, 1);
    endtask

    task automatic pop(output logic [23:0] a, b);
        logic k;
        k = 0;
        @(posedge sys_clk);
        out_ready <= 1;
        while (!k) begin
            @(negedge sys_clk);
            k = out_valid;
            a = out_ch2;
            b = out_ch3;
            @(posedge sys_clk);
            if (k) out_ready <= 0;
        end
        @(negedge sys_clk);
        chk(smp_ready, 1);
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_buf;
        logic [23:0] a, b;
        logic [31:0] d;
        logic [1:0]  r;
        push(1, -1);
        push(2, -2);
        @(negedge sys_clk);
        chk(smp_ready, 0);
        rd(IDX_STATUS, d, r);
        chk(d, 32'(1 << ST_FULL | 1 << ST_VALID));
        pop(a, b);
        chk({a, b}, {24'h1, 24'hffffff});
        pop(a, b);
        chk({a, b}, {24'h2, 24'hfffffe});
        @(negedge sys_clk);
        chk(out_valid, 0);
        $display("buffer test done");
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 6; i++) begin
            rd(ia[i], d, r);
            chk(d, {24'h0, ra[i]});
            wr(ia[i], ma[i], r);
            rd(ia[i], d, r);
            chk(d, {24'h0, ma[i]});
        end
        wr(8'h10, 8'h55, r);
        chk(r, RESP_SLVERR);
        rd(8'h10, d, r);
        chk(r, RESP_SLVERR);
        $display("register test done");
    endtask

    task automatic t_phase;
        logic [5:0] c[3] = '{6'd0, 6'd1, 6'd63};
        logic [1:0] r;
        logic [3:0] p;
        for (int j = 0; j < 3; j++) begin
            wr(IDX_CH2_PHASE_DELAY, {c[j], 2'h0}, r);
            wr(IDX_CH3_INPUT_COPY, {j[0], 7'h0}, r);
            for (int i = 0; i < 80; i++) begin
                p = 4'(i * 7);
                @(posedge sys_clk);
                ch2_mod <= 4'(i * 7);
                ch1_mod <= ~4'(i * 7);
                ch3_mod <= 4'(i * 7 + 5);
                mod_tick <= 1;
                @(posedge sys_clk);
                mod_tick <= 0;
                #1;
                if (i >= c[j]) chk(ch2_filt_in, 4'((i - c[j]) * 7));
                chk(ch3_filt_in, j[0] ? {~p} : {p + 4'h5});
            end
        end
        $display("phase test done");
    endtask

    task automatic t_gain;
        logic [7:0]  v[7] = '{161, 162, 1, 255, 161, 161, 0};
        logic [3:0]  t[7] = '{8, 8, 8, 8, 0, 15, 8};
        int          x[7] = '{4000000, 4000000, 4000000, 1000, 4000000,
                              4000000, 4000000};
        logic [23:0] a, b;
        logic [1:0]  r;
        logic [31:0] d;
        for (int i = 0; i < 7; i++) begin
            wr(IDX_CH2_VOLUME, v[i], r);
            wr(IDX_CH3_VOLUME, v[i], r);
            wr(IDX_CH2_GAIN_TRIM, {t[i], 4'h0}, r);
            wr(IDX_CH3_GAIN_TRIM, {t[i], 4'h0}, r);
            push(x[i], -x[i]);
            pop(a, b);
            if (v[i] == 0) begin
                chk({a, b}, 0);
                rd(IDX_STATUS, d, r);
                chk(d, 32'(1 << ST_MUTE2 | 1 << ST_MUTE3));
            end else begin
                near(a, x[i], v[i], t[i]);
                near(b, -x[i], v[i], t[i]);
            end
        end
        $display("gain test done");
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1;
        t_buf;
        t_regs;
        t_phase;
        t_gain;
        report_and_stop;
    end

    initial begin
        #200000;
        n_errors++;
        report_and_stop;
    end
endmodule
